// File: src/timer16_regs_pkg.sv
// Purpose: shared constants and types of the 16-bit timer control/status block
// Assumes: registers are 8 bits wide, one per aligned 32-bit bus word
// Notes:   printed offsets are register indices; byte address is four times the index
package timer16_regs_pkg;

   // register indices; byte address = index * 4
   localparam logic [3:0] IDX_CMD_LOCK_DIR_CLEAR = 4'h4;
   localparam logic [3:0] IDX_CMD_LOCK_DIR_SET   = 4'h5;
   localparam logic [3:0] IDX_BUFFER_VALID_CLEAR = 4'h6;
   localparam logic [3:0] IDX_BUFFER_VALID_SET   = 4'h7;
   localparam logic [3:0] IDX_EVENT_INPUT_CTRL   = 4'h9;
   localparam logic [3:0] IDX_INTERRUPT_ENABLE   = 4'ha;
   localparam logic [3:0] IDX_INTERRUPT_FLAGS    = 4'hb;
   localparam logic [3:0] IDX_DEBUG_BEHAVIOUR    = 4'he;
   localparam logic [3:0] IDX_BYTE_STAGING       = 4'hf;
   localparam int         ADDR_IDX_LSB           = 2;
   localparam int         ADDR_IDX_MSB           = 5;

   // field positions
   localparam int DIR_BIT          = 0;
   localparam int LOCK_BIT         = 1;
   localparam int CMD_LSB          = 2;
   localparam int CMD_MSB          = 3;
   localparam int EV_COUNT_EN_BIT  = 0;
   localparam int EV_ACTION_LSB    = 1;
   localparam int EV_ACTION_MSB    = 2;
   localparam int WRAP_BIT         = 0;
   localparam int CMP0_BIT         = 4;
   localparam int RUN_HALTED_BIT   = 0;
   localparam int NUM_CHANNELS     = 3;

   // reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [2:0] RST_EVENT_INPUT_CONTROL = 3'h0;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // software command field
   typedef enum logic [1:0] {
      cmd_none       = 2'b00,
      cmd_update     = 2'b01,
      cmd_restart    = 2'b10,
      cmd_hard_reset = 2'b11
   } command_t;

   // event action select
   typedef enum logic [1:0] {
      rising_edge_action       = 2'b00,
      either_edge_action       = 2'b01,
      level_gated_action       = 2'b10,
      direction_by_event_action = 2'b11
   } event_action_t;

   // waveform select codes
   localparam logic [2:0] WAVE_NORMAL      = 3'h0;
   localparam logic [2:0] WAVE_FREQUENCY   = 3'h1;
   localparam logic [2:0] WAVE_SINGLESLOPE = 3'h3;
   localparam logic [2:0] WAVE_DS_TOP      = 3'h5;
   localparam logic [2:0] WAVE_DS_BOTH     = 3'h6;
   localparam logic [2:0] WAVE_DS_BOTTOM   = 3'h7;

endpackage

// File: src/set_clear_bits.sv
// Purpose: group of sticky status bits with set and clear strobes
// Assumes: set and clear are one-cycle pulses in the i_ref_clk domain
// Notes:   set wins over clear so a same-cycle event is never lost
`timescale 1ns/100ps
module set_clear_bits #(
   parameter int unsigned WIDTH = 4
) (
   // clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_arst_n,
   // strobes
   input  wire logic [WIDTH-1:0] i_set,
   input  wire logic [WIDTH-1:0] i_clear,
   // state
   output logic      [WIDTH-1:0] o_bits
);
   import timer16_regs_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] bits;
   } bits_state_t;

   bits_state_t r;
   bits_state_t next_r;

   // zero bits in either strobe leave the bit alone
   always_comb begin
      next_r      = r;
      next_r.bits = (r.bits & ~i_clear) | i_set; // [RQ26]
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r.bits <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_bits = r.bits;

endmodule // set_clear_bits

// File: src/timer16_control_status_regs.sv
// Purpose: control, status and flag registers of a 16-bit timer/counter, AXI4-Lite slave
// Assumes: counter, period, compare and buffer data live outside; inputs are synchronous
// Notes:   counting strobe and direction go out to the external counter datapath
// Overview of operation
// (RQ1) Writing one to a set-view bit sets it, others untouched.
// (RQ2) Lock and direction read the same through set view and clear view.
// (RQ3) Command field values 0..3: none, buffer update, restart, hard reset.
// (RQ4) Command field always reads back as zero.
// (RQ5) Hard reset command is ignored while the timer is enabled.
// (RQ6) Lock set blocks buffer loads on update; lock clear loads at once (clearing lock here only lets the next update load).
// (RQ7) Direction zero counts up, one counts down.
// (RQ8) Hardware drives direction, but software writes also take effect.
// (RQ9) Writing one to buffer-valid clear view clears that flag alone.
// (RQ10) Writing one to buffer-valid set view sets that flag alone.
// (RQ11) Compare buffer-valid flag sets whenever its compare buffer is written.
// (RQ12) Compare buffer-valid flags clear on an update condition.
// (RQ13) Period buffer-valid flag sets on buffer write, clears on update.
// (RQ14) Action 0 counts rising event edges; action 1 counts both edges.
// (RQ15) Action 2 counts prescaled ticks only while event input is high.
// (RQ16) Action 3 counts prescaled ticks, up when event low, down when high.
// (RQ17) Event counting only when event-count enable is one.
// (RQ18) Enable bits 4..6 gate compare requests, bit 0 gates wrap request.
// (RQ19) Compare flag sets when counter equals that channel's compare value.
// (RQ20) Compare flags never clear by hardware; software writes one to clear.
// (RQ21) Wrap flag sets at top or bottom per waveform mode; sticky.
// (RQ22) Run-while-halted zero freezes timer and ignores events in debug break.
// (RQ23) One shared byte staging register, readable and writable by software.
// (RQ24) On update, compare registers load from buffers unless locked.
// (RQ25) Normal and frequency modes update at top; slope modes at bottom.
// (RQ26) Writing zero to set, clear and flag bits changes nothing.
// (RQ27) Low-byte read captures high byte; staged high write waits for low.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module timer16_control_status_regs (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   // axi4-lite write address and data
   input  wire logic [31:0] i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   // axi4-lite write response
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // axi4-lite read
   input  wire logic [31:0] i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // timer datapath status
   input  wire logic        i_tc_enable,
   input  wire logic [2:0]  i_waveform_select,
   input  wire logic [15:0] i_counter_value,
   input  wire logic [15:0] i_period_value,
   input  wire logic [47:0] i_compare_values,
   input  wire logic        i_prescale_tick,
   input  wire logic        i_hw_dir_load,
   input  wire logic        i_hw_dir,
   // buffer writes seen by the datapath
   input  wire logic        i_period_buf_write,
   input  wire logic [2:0]  i_compare_buf_write,
   // event and debug
   input  wire logic        i_event_in,
   input  wire logic        i_debug_halt,
   // 16-bit access through the staging byte
   input  wire logic        i_wide_low_read,
   input  wire logic [7:0]  i_wide_high_byte,
   input  wire logic        i_wide_high_write,
   input  wire logic [7:0]  i_wide_high_data,
   input  wire logic        i_wide_low_write,
   output logic             o_pair_commit,
   output logic [7:0]       o_pair_high,
   // counter control
   output logic             o_count_step,
   output logic             o_count_dir,
   output logic             o_buffer_load,
   output logic             o_force_restart,
   output logic             o_force_hard_reset,
   // interrupt requests
   output logic             o_wrap_request,
   output logic [2:0]       o_compare_request
);
   import timer16_regs_pkg::*;

   typedef struct packed {
      logic       aw_held;
      logic [3:0] aw_idx;
      logic       aw_bad;
      logic       w_held;
      logic [7:0] w_data;
      logic       w_lane;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic       lock;
      logic       dir;
      logic [2:0] ev_ctrl;
      logic [3:0] int_en;
      logic       run_halted;
      logic [7:0] staging;
      logic       ev_prev;
      logic       buffer_load;
      logic       restart;
      logic       hard_reset;
      logic       pair_commit;
   } ctrl_state_t;

   ctrl_state_t r;
   ctrl_state_t next_r;

   logic          wr_fire;
   logic [3:0]    ar_idx;
   logic          ar_bad;
   logic [3:0]    aw_idx_in;
   logic          aw_bad_in;
   logic [7:0]    wr_byte;
   logic [3:0]    bufv;
   logic [3:0]    flags;
   logic [3:0]    bufv_set;
   logic [3:0]    bufv_clear;
   logic [3:0]    flag_set;
   logic [3:0]    flag_clear;
   logic          halted;
   logic          step_now;
   logic          top_hit;
   logic          bottom_hit;
   logic          update_at_top;
   logic          update_cond;
   logic          wrap_cond;
   logic          force_update;
   logic [2:0]    cmp_match;
   command_t      cmd_written;
   event_action_t ev_action;

   // address decode: only aligned, low, mapped words answer okay
   function automatic logic idx_unmapped(input logic [31:0] addr);
      logic [3:0] idx;
      logic       known;
      idx   = addr[ADDR_IDX_MSB:ADDR_IDX_LSB];
      known = (idx == IDX_CMD_LOCK_DIR_CLEAR) || (idx == IDX_CMD_LOCK_DIR_SET) ||
              (idx == IDX_BUFFER_VALID_CLEAR) || (idx == IDX_BUFFER_VALID_SET) ||
              (idx == IDX_EVENT_INPUT_CTRL)   || (idx == IDX_INTERRUPT_ENABLE) ||
              (idx == IDX_INTERRUPT_FLAGS)    || (idx == IDX_DEBUG_BEHAVIOUR)  ||
              (idx == IDX_BYTE_STAGING);
      return !known || (addr[31:ADDR_IDX_MSB+1] != 26'h0) || (addr[1:0] != 2'h0);
   endfunction

   assign ar_idx    = i_araddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
   assign ar_bad    = idx_unmapped(i_araddr);
   assign aw_idx_in = i_awaddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
   assign aw_bad_in = idx_unmapped(i_awaddr);

   // write acts once both halves are held; a write without lane 0 changes nothing
   assign wr_fire     = r.aw_held && r.w_held && !r.bvalid;
   assign wr_byte     = (wr_fire && r.w_lane && !r.aw_bad) ? r.w_data : 8'h00;
   assign cmd_written = (r.aw_idx == IDX_CMD_LOCK_DIR_SET) ?
                        command_t'(wr_byte[CMD_MSB:CMD_LSB]) : cmd_none; // [RQ3]
   assign ev_action   = event_action_t'(r.ev_ctrl[EV_ACTION_MSB:EV_ACTION_LSB]);

   // debug break freezes counting unless told to keep running
   assign halted = i_debug_halt && !r.run_halted; // [RQ22]

   // count strobe selection
   always_comb begin
      step_now = 1'b0;
      if (!r.ev_ctrl[EV_COUNT_EN_BIT]) begin
         step_now = i_prescale_tick; // [RQ17]
      end else begin
         case (ev_action)
            rising_edge_action:        step_now = i_event_in && !r.ev_prev; // [RQ14]
            either_edge_action:        step_now = i_event_in != r.ev_prev; // [RQ14]
            level_gated_action:        step_now = i_prescale_tick && i_event_in; // [RQ15]
            direction_by_event_action: step_now = i_prescale_tick; // [RQ16]
            default:                   step_now = 1'b0;
         endcase
      end
      step_now = step_now && i_tc_enable && !halted;
   end

   // top and bottom points, with update and wrap placement by waveform
   assign top_hit       = step_now && !r.dir && (i_counter_value == i_period_value);
   assign bottom_hit    = step_now && r.dir && (i_counter_value == 16'h0000);
   assign update_at_top = (i_waveform_select == WAVE_NORMAL) ||
                          (i_waveform_select == WAVE_FREQUENCY); // [RQ25]
   assign force_update  = (cmd_written == cmd_update);
   assign update_cond   = (update_at_top ? top_hit : bottom_hit) || force_update; // [RQ25]

   always_comb begin
      case (i_waveform_select)
         WAVE_NORMAL, WAVE_FREQUENCY, WAVE_DS_TOP: wrap_cond = top_hit; // [RQ21]
         WAVE_SINGLESLOPE, WAVE_DS_BOTTOM:         wrap_cond = bottom_hit; // [RQ21]
         WAVE_DS_BOTH:                             wrap_cond = top_hit || bottom_hit;
         default:                                  wrap_cond = 1'b0;
      endcase
   end

   // compare equality per channel
   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_match
      assign cmp_match[ch] = i_tc_enable &&
                             (i_counter_value == i_compare_values[16*ch +: 16]); // [RQ19]
   end

   // buffer-valid strobes; hardware writes set, loads clear, set wins
   assign bufv_set   = {i_compare_buf_write, i_period_buf_write} | // [RQ11] [RQ13]
                       ((r.aw_idx == IDX_BUFFER_VALID_SET) ? wr_byte[3:0] : 4'h0); // [RQ10]
   assign bufv_clear = ((update_cond && !r.lock) ? 4'hf : 4'h0) | // [RQ12] [RQ13]
                       ((r.aw_idx == IDX_BUFFER_VALID_CLEAR) ? wr_byte[3:0] : 4'h0); // [RQ9]

   // flag strobes; no hardware clear path exists
   assign flag_set   = {cmp_match, wrap_cond}; // [RQ19] [RQ21]
   assign flag_clear = (r.aw_idx == IDX_INTERRUPT_FLAGS) ?
                       {wr_byte[CMP0_BIT+2:CMP0_BIT], wr_byte[WRAP_BIT]} : 4'h0; // [RQ20]

   set_clear_bits #(.WIDTH(4)) u_buffer_valid (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_set     (bufv_set),
      .i_clear   (bufv_clear),
      .o_bits    (bufv)
   );

   set_clear_bits #(.WIDTH(4)) u_flags (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_set     (flag_set),
      .i_clear   (flag_clear),
      .o_bits    (flags)
   );

   // next-state for bus, control fields, staging and strobes
   always_comb begin
      next_r             = r;
      next_r.buffer_load = update_cond && !r.lock; // [RQ6] [RQ24]
      next_r.restart     = (cmd_written == cmd_restart);
      next_r.hard_reset  = (cmd_written == cmd_hard_reset) && !i_tc_enable; // [RQ5]
      next_r.pair_commit = i_wide_low_write; // [RQ27]
      next_r.ev_prev     = i_event_in;
      // write address and data are taken in either order
      if (i_awvalid && o_awready) begin
         next_r.aw_held = 1'b1;
         next_r.aw_idx  = aw_idx_in;
         next_r.aw_bad  = aw_bad_in;
      end
      if (i_wvalid && o_wready) begin
         next_r.w_held = 1'b1;
         next_r.w_data = i_wdata[7:0];
         next_r.w_lane = i_wstrb[0];
      end
      if (wr_fire) begin
         next_r.aw_held = 1'b0;
         next_r.w_held  = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = r.aw_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (r.bvalid && i_bready) begin
         next_r.bvalid = 1'b0;
      end
      // hardware direction first; a software write in the same cycle overrides it
      if (r.ev_ctrl[EV_COUNT_EN_BIT] && ev_action == direction_by_event_action &&
          !halted) begin
         next_r.dir = i_event_in; // [RQ16] [RQ8]
      end else if (i_hw_dir_load) begin
         next_r.dir = i_hw_dir; // [RQ8]
      end
      case (r.aw_idx)
         IDX_CMD_LOCK_DIR_SET: begin
            next_r.lock = r.lock | wr_byte[LOCK_BIT]; // [RQ1] [RQ26]
            next_r.dir  = wr_byte[DIR_BIT] ? 1'b1 : next_r.dir; // [RQ1] [RQ8]
         end
         IDX_CMD_LOCK_DIR_CLEAR: begin
            next_r.lock = r.lock & ~wr_byte[LOCK_BIT]; // [RQ26]
            next_r.dir  = wr_byte[DIR_BIT] ? 1'b0 : next_r.dir; // [RQ8]
         end
         IDX_EVENT_INPUT_CTRL: begin
            if (wr_fire && r.w_lane && !r.aw_bad) begin
               next_r.ev_ctrl = r.w_data[EV_ACTION_MSB:0];
            end
         end
         IDX_INTERRUPT_ENABLE: begin
            if (wr_fire && r.w_lane && !r.aw_bad) begin
               next_r.int_en = {r.w_data[CMP0_BIT+2:CMP0_BIT], r.w_data[WRAP_BIT]}; // [RQ18]
            end
         end
         IDX_DEBUG_BEHAVIOUR: begin
            if (wr_fire && r.w_lane && !r.aw_bad) begin
               next_r.run_halted = r.w_data[RUN_HALTED_BIT]; // [RQ22]
            end
         end
         IDX_BYTE_STAGING: begin
            if (wr_fire && r.w_lane && !r.aw_bad) begin
               next_r.staging = r.w_data; // [RQ23]
            end
         end
         default: begin
            next_r.lock = r.lock;
         end
      endcase
      // datapath accesses take the staging byte over a same-cycle software write
      if (i_wide_low_read) begin
         next_r.staging = i_wide_high_byte; // [RQ27]
      end else if (i_wide_high_write) begin
         next_r.staging = i_wide_high_data; // [RQ27]
      end
      // read answer one cycle after the address is taken
      if (i_arvalid && o_arready) begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = ar_bad ? RESP_SLVERR : RESP_OKAY;
         next_r.rdata  = 8'h00;
         if (!ar_bad) begin
            case (ar_idx)
               IDX_CMD_LOCK_DIR_CLEAR, IDX_CMD_LOCK_DIR_SET:
                  next_r.rdata = {4'h0, 2'b00, r.lock, r.dir}; // [RQ2] [RQ4]
               IDX_BUFFER_VALID_CLEAR, IDX_BUFFER_VALID_SET:
                  next_r.rdata = {4'h0, bufv};
               IDX_EVENT_INPUT_CTRL: next_r.rdata = {5'h00, r.ev_ctrl};
               IDX_INTERRUPT_ENABLE: next_r.rdata = {1'b0, r.int_en[3:1], 3'h0, r.int_en[0]};
               IDX_INTERRUPT_FLAGS:  next_r.rdata = {1'b0, flags[3:1], 3'h0, flags[0]};
               IDX_DEBUG_BEHAVIOUR:  next_r.rdata = {7'h00, r.run_halted};
               IDX_BYTE_STAGING:     next_r.rdata = r.staging; // [RQ23]
               default:              next_r.rdata = 8'h00;
            endcase
         end
      end else if (r.rvalid && i_rready) begin
         next_r.rvalid = 1'b0;
      end
   end

   // state register; every field resets to a constant
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '0;
         r.ev_ctrl <= RST_EVENT_INPUT_CONTROL;
         r.int_en  <= RST_NIBBLE;
         r.staging <= RST_BYTE;
      end else begin
         r <= next_r;
      end
   end

   // handshakes are combinational; data comes from flops
   assign o_awready          = !r.aw_held && !r.bvalid;
   assign o_wready           = !r.w_held && !r.bvalid;
   assign o_arready          = !r.rvalid;
   assign o_bvalid           = r.bvalid;
   assign o_bresp            = r.bresp;
   assign o_rvalid           = r.rvalid;
   assign o_rresp            = r.rresp;
   assign o_rdata            = {24'h000000, r.rdata};
   assign o_count_step       = step_now;
   assign o_count_dir        = r.dir; // [RQ7]
   assign o_buffer_load      = r.buffer_load;
   assign o_force_restart    = r.restart;
   assign o_force_hard_reset = r.hard_reset;
   assign o_pair_commit      = r.pair_commit;
   assign o_pair_high        = r.staging; // [RQ27]
   assign o_wrap_request     = flags[0] && r.int_en[0]; // [RQ18]
   assign o_compare_request  = flags[3:1] & r.int_en[3:1]; // [RQ18]

   // named steps of a write to the set view
   sequence s_lock_set_write;
      wr_fire && r.w_lane && !r.aw_bad && (r.aw_idx == IDX_CMD_LOCK_DIR_SET) &&
      r.w_data[LOCK_BIT];
   endsequence

   sequence s_lock_seen;
      r.lock ##1 r.lock;
   endsequence

   a_lock_set_view: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ1]
      s_lock_set_write ##1 !(wr_fire && r.aw_idx == IDX_CMD_LOCK_DIR_CLEAR) |-> s_lock_seen)
      else $error("lock not set by set-view write");

   a_cmd_reads_zero: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ4]
      (i_arvalid && o_arready && !ar_bad && ar_idx == IDX_CMD_LOCK_DIR_SET) |=>
      (o_rvalid && o_rdata[CMD_MSB:CMD_LSB] == 2'b00))
      else $error("command field read nonzero");

   a_views_agree: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ2]
      (i_arvalid && o_arready && !ar_bad && ar_idx == IDX_CMD_LOCK_DIR_CLEAR) |=>
      (o_rdata[1:0] == {$past(r.lock), $past(r.dir)}))
      else $error("clear view disagrees with state");

   a_hard_reset_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ5]
      o_force_hard_reset |-> !$past(i_tc_enable))
      else $error("hard reset issued while enabled");

   a_lock_blocks_load: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ6]
      (update_cond && r.lock) |=> !o_buffer_load)
      else $error("buffer load while locked");

   a_load_clears_valid: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ12]
      (update_cond && !r.lock && bufv_set == 4'h0) |=> (o_buffer_load && bufv == 4'h0))
      else $error("buffer-valid not cleared by load");

   a_halt_no_step: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ22]
      (i_debug_halt && !r.run_halted) |-> !o_count_step)
      else $error("counting during debug break");

   a_match_sets_flag: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ19]
      cmp_match[1] |=> flags[2])
      else $error("compare match flag not set");

   a_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ21]
      (flags[0] && !flag_clear[0]) |=> flags[0])
      else $error("wrap flag cleared without software");

   a_updown_dir: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // [RQ16]
      (r.ev_ctrl == 3'b111 && !halted && !wr_fire) |=> (o_count_dir == $past(i_event_in)))
      else $error("direction does not follow event level");

endmodule // timer16_control_status_regs

// File: bench/test_timer16_control_status_regs.sv
// Purpose: self-checking bench for the timer control and status registers
// Assumes: bench acts as axi4-lite master and drives the datapath inputs
// Notes:   pulses and steps are counted mid-cycle against an integer model
`timescale 1ns/100ps
module test_timer16_control_status_regs;
   import timer16_regs_pkg::*;
   // stimulus, valued at time zero; strobe and waveform select stay fixed
   logic        i_ref_clk = 0, i_arst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   logic        i_arvalid = 0, i_rready = 0, i_tc_enable = 0, i_prescale_tick = 0;
   logic        i_hw_dir = 0, i_hw_dir_load = 0, i_period_buf_write = 0, i_event_in = 0;
   logic        i_debug_halt = 0, i_wide_low_read = 0, i_wide_high_write = 0;
   logic        i_wide_low_write = 0, p = 0;
   logic [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0, o_rdata;
   logic [3:0]  i_wstrb = 4'h1;
   logic [2:0]  i_waveform_select = 0, i_compare_buf_write = 0, o_compare_request;
   logic [15:0] i_counter_value = 16'h1234, i_period_value = 16'hffff;
   logic [47:0] i_compare_values = 0;
   logic [7:0]  i_wide_high_byte = 0, i_wide_high_data = 0, o_pair_high, ph, r;
   logic [1:0]  o_bresp, o_rresp;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pair_commit;
   logic        o_count_step, o_count_dir, o_buffer_load, o_force_restart;
   logic        o_force_hard_reset, o_wrap_request;
   int          err_total = 0, comparisons = 0, n_hr = 0, n_rs = 0, n_bl = 0;
   int          n_st = 0, e_st = 0, ev = 0, act = 0, run = 0, k;
   timer16_control_status_regs DUT (.*);
   always #4 i_ref_clk = ~i_ref_clk;
   // model of the step strobe; sampled at negedge since the strobe is combinational
   always @(negedge i_ref_clk) begin
      n_hr += o_force_hard_reset;
      n_rs += o_force_restart;
      n_bl += o_buffer_load;
      n_st += o_count_step;
      if (o_pair_commit) ph = o_pair_high;
      if (i_tc_enable && !(i_debug_halt && !run))
         e_st += !ev ? i_prescale_tick : act == 0 ? i_event_in && !p : act == 1 ?
                 i_event_in ^ p : act == 2 ? i_prescale_tick && i_event_in : i_prescale_tick;
      p = i_event_in;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
      logic ka, kw, kb;
      kb = 0;
      i_awaddr <= {26'h0, a, 2'b00};
      i_wdata <= {24'h0, d};
      {i_awvalid, i_wvalid, i_bready} <= 3'h7;
      for (int n = 0; n < 50 && !kb; n++) begin
         @(negedge i_ref_clk);
         {ka, kw, kb} = {i_awvalid & o_awready, i_wvalid & o_wready, o_bvalid};
         if (kb) chk(32'(o_bresp), 32'(e));
         @(posedge i_ref_clk);
         if (ka) i_awvalid <= 0;
         if (kw) i_wvalid <= 0;
      end
      if (!kb) err_total++;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
      logic ka, kb;
      kb = 0;
      i_araddr <= {26'h0, a, 2'b00};
      {i_arvalid, i_rready} <= 2'h3;
      for (int n = 0; n < 50 && !kb; n++) begin
         @(negedge i_ref_clk);
         {ka, kb} = {i_arvalid & o_arready, o_rvalid};
         if (kb) chk({o_rresp, o_rdata[29:0]}, {e, 22'h0, d});
         @(posedge i_ref_clk);
         if (ka) i_arvalid <= 0;
      end
      if (!kb) err_total++;
   endtask
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // a hang is cut short long after the expected few hundred cycles
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   initial begin
      void'($urandom(74));
      cyc(10);
      i_arst_n <= 1;
      cyc(1);
      // reset values over indices 4 to 15; holes answer with an error
      for (k = 4; k < 16; k++) rd(4'(k), 8'h00, k inside {8, 12, 13} ? RESP_SLVERR : RESP_OKAY);
      r = 8'($urandom);
      wr(4'hf, r);
      rd(4'hf, r);
      {i_wide_low_read, i_wide_high_byte} <= {1'b1, ~r};
      cyc(1);
      i_wide_low_read <= 0;
      rd(4'hf, ~r);
      {i_wide_high_write, i_wide_high_data} <= {1'b1, r ^ 8'h5a};
      cyc(1);
      {i_wide_high_write, i_wide_low_write} <= 2'h1;
      cyc(1);
      i_wide_low_write <= 0;
      cyc(2);
      chk(ph, r ^ 8'h5a);
      $display("test staging done");
      wr(4'h5, 8'h0c);
      i_tc_enable <= 1;
      wr(4'h5, 8'h0f);
      rd(4'h4, 8'h03);
      rd(4'h5, 8'h03);
      wr(4'h5, 8'h08);
      wr(4'h5, 8'h04);
      wr(4'h4, 8'h01);
      rd(4'h5, 8'h02);
      chk(n_hr * 16 + n_rs * 4 + n_bl, 32'h14);
      wr(4'h7, 8'h05);
      wr(4'h6, 8'h01);
      rd(4'h6, 8'h04);
      {i_period_buf_write, i_compare_buf_write} <= 4'h9;
      cyc(1);
      {i_period_buf_write, i_compare_buf_write} <= 4'h0;
      rd(4'h7, 8'h07);
      $display("test control done");
      // every event action, then event counting off; halt random, run-in-debug alternating
      for (k = 0; k < 5; k++) begin
         wr(4'h9, k < 4 ? {5'h0, k[1:0], 1'b1} : 8'h00);
         wr(4'he, {7'h0, k[0]});
         {ev, act, run} = {32'(k < 4), k, k % 2};
         repeat (40) begin
            cyc(1);
            {i_event_in, i_prescale_tick, i_debug_halt} <= 3'($urandom);
         end
         cyc(1);
         {i_prescale_tick, i_debug_halt} <= 2'h0;
         if (k == 3) r = {7'h0, i_event_in};
      end
      chk(n_st, e_st);
      chk(o_count_dir, r);
      rd(4'h4, {7'h1, r[0]});
      {i_hw_dir_load, i_hw_dir} <= 2'h3;
      cyc(1);
      i_hw_dir_load <= 0;
      rd(4'h4, 8'h03);
      $display("test events done");
      wr(4'h4, 8'h01);
      i_compare_values <= {16'h0, 16'h1234, 16'h0};
      cyc(2);
      i_compare_values <= 0;
      wr(4'ha, 8'h21);
      rd(4'hb, 8'h20);
      chk({o_wrap_request, o_compare_request}, 32'h2);
      wr(4'hb, 8'h20);
      for (k = 0; k < 2; k++) begin
         {i_counter_value, i_prescale_tick} <= {16'hffff, 1'b1};
         cyc(1);
         i_prescale_tick <= 0;
         rd(4'hb, 8'h01);
         rd(4'h6, k ? 8'h00 : 8'h07);
         if (!k) wr(4'h4, 8'h02);
      end
      chk(n_bl, 1);
      $display("test update done");
      conclude();
   end
endmodule // test_timer16_control_status_regs
